/* File: hw/nvac_map.svh */
/*
 Constants of the data nonvolatile access controller: register offsets,
 field positions, reset values and timing counts.
 Assumes inclusion by bare name from the package and the modules.
*/
`ifndef NVAC_MAP_SVH
`define NVAC_MAP_SVH

// ****************************************
// Register locations
// ****************************************
`define NVAC_CTRL_PTR 8'h40
`define NVAC_CTRL_BANK 1'h1
`define NVAC_ADDR_OFS 8'h00
`define NVAC_DATA_OFS 8'h01
`define NVAC_BANK_OFS 8'h02

// ****************************************
// Control fields
// ****************************************
`define NVAC_PROG_PERMIT_BIT 3
`define NVAC_PROG_START_BIT 2
`define NVAC_READ_PERMIT_BIT 1
`define NVAC_READ_START_BIT 0

// ****************************************
// Reset values and sizes
// ****************************************
`define NVAC_CTRL_RST 4'h0
`define NVAC_ADDR_RST 6'h00
`define NVAC_DATA_RST 8'h00
`define NVAC_DEPTH 64

// ****************************************
// Timing
// ****************************************
`define NVAC_CLK_NS 100
`define NVAC_PROG_TIME_US 20
`define NVAC_PROG_CYCLES ((`NVAC_PROG_TIME_US * 1000 + `NVAC_CLK_NS - 1) / `NVAC_CLK_NS)
`define NVAC_READ_CYCLES 2

`endif

/* File: hw/nvac_pkg.sv */
/*
 Types of the data nonvolatile access controller.
 Assumes nvac_map.svh on the include path.
*/
`include "nvac_map.svh"

package nvac_pkg;
  typedef enum logic [1:0] {
    NVAC_IDLE,
    NVAC_READ,
    NVAC_PROG
  } nvac_state_t;
  typedef logic [5:0] nvac_addr_t;
  typedef logic [7:0] nvac_byte_t;
endpackage

/* File: hw/nvac_array_if.sv */
/*
 Interface between the controller and its storage array.
 Assumes one clock domain.
*/
`timescale 1ns/1ps

interface nvac_array_if;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  modport ctrl (output addr, output wdata, output wr, input rdata);
  modport mem (input addr, input wdata, input wr, output rdata);
endinterface

/* File: hw/nvac_array.sv */
/*
 The 64 x 8 nonvolatile storage, held in flip-flops.
 Assumes the controller issues single-cycle write strobes.
*/
`timescale 1ns/1ps
`include "nvac_map.svh"

module nvac_array
  import nvac_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Port
  nvac_array_if.mem port
);
  nvac_byte_t mem_q [`NVAC_DEPTH];
  nvac_byte_t mem_d [`NVAC_DEPTH];

  // Contents survive reset, as a nonvolatile store should
  always_comb begin
    mem_d = mem_q;
    if (port.wr) begin
      mem_d[port.addr] = port.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    mem_q <= mem_d;
  end

  assign port.rdata = mem_q[port.addr];
endmodule

/* File: hw/nvac_top.sv */
/*
 Data nonvolatile access controller: address, data and control registers,
 bank select, read and self-timed program cycles, and the completion
 interrupt flags.
 Assumes a CPU register port with one-cycle read and write strobes, with
 the special-function/bank decode resolved into the strobes below.
 Assumes the program time is set through PROG_CYCLES; the timer counts
 system clocks here, so software must still poll the start bit rather
 than count instructions.
 Assumes the storage array keeps its contents through reset.
*/
`timescale 1ns/1ps
`include "nvac_map.svh"

module nvac_top
  import nvac_pkg::*;
#(
  parameter int PROG_CYCLES = `NVAC_PROG_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Direct special-function register port
  input wire logic dir_wr_in,
  input wire logic [7:0] dir_addr_in,
  input wire logic [7:0] dir_wdata_in,
  // Indirect access port one
  input wire logic ind_wr_in,
  input wire logic [7:0] indirect_pointer_one_in,
  input wire logic [7:0] ind_wdata_in,
  // Interrupt control
  input wire logic global_irq_enable_in,
  input wire logic nv_update_done_irq_enable_in,
  input wire logic mf_irq_enable_in,
  input wire logic stack_full_in,
  input wire logic done_flag_clr_in,
  input wire logic mf_service_in,
  // Read data
  output logic [7:0] dir_rdata_out,
  output logic [7:0] ind_rdata_out,
  // Status
  output logic nv_update_done_flag_out,
  output logic mf_irq_flag_out,
  output logic irq_vector_out,
  output logic busy_out
);
  // ****************************************
  // Reset release
  // ****************************************
  // Asserts at once, releases only on clock edges
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ****************************************
  // State
  // ****************************************
  nvac_array_if arr ();
  nvac_state_t state_q, state_d;
  logic [3:0] ctrl_q, ctrl_d;
  nvac_addr_t addr_q, addr_d;
  nvac_byte_t data_q, data_d;
  logic bank_q, bank_d;
  nvac_addr_t lat_addr_q, lat_addr_d;
  nvac_byte_t lat_data_q, lat_data_d;
  logic [15:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic mf_q, mf_d;
  logic vec_q, vec_d;
  logic [7:0] dir_rd_q, dir_rd_d;
  logic [7:0] ind_rd_q, ind_rd_d;
  logic busy_q, busy_d;
  logic prog_end;

  // ****************************************
  // Control decode
  // ****************************************
  // Indirect hit on the control register needs both pointer and bank
  function automatic logic ctrl_hit(input logic [7:0] ptr, input logic bank);
    return (ptr == `NVAC_CTRL_PTR) && (bank == `NVAC_CTRL_BANK);
  endfunction

  // A start only takes when its own permit stood before this write
  function automatic logic start_ok(input logic req, input logic permit);
    return req && permit;
  endfunction

  logic ind_ctrl_wr;
  assign ind_ctrl_wr = ind_wr_in && ctrl_hit(indirect_pointer_one_in, bank_q);
  // Last cycle of a program: array write and both flag sets land together
  assign prog_end = (state_q == NVAC_PROG) && (cnt_q == 16'h0000);

  // ****************************************
  // Storage array
  // ****************************************
  nvac_array u_array (
    .clk_in(clk_in),
    .port(arr.mem)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_d = state_q;
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    data_d = data_q;
    bank_d = bank_q;
    lat_addr_d = lat_addr_q;
    lat_data_d = lat_data_q;
    cnt_d = cnt_q;
    arr.addr = lat_addr_q;
    arr.wdata = lat_data_q;
    arr.wr = 1'b0;

    // Upper address bits are not stored, so they read back as zero
    if (dir_wr_in) begin
      case (dir_addr_in)
        `NVAC_ADDR_OFS: addr_d = dir_wdata_in[5:0];
        `NVAC_DATA_OFS: data_d = dir_wdata_in;
        `NVAC_BANK_OFS: bank_d = dir_wdata_in[0];
        default: ;
      endcase
    end

    // Starts latch only when their permit already stands in the register
    if (ind_ctrl_wr) begin
      ctrl_d[`NVAC_PROG_PERMIT_BIT] = ind_wdata_in[`NVAC_PROG_PERMIT_BIT];
      ctrl_d[`NVAC_READ_PERMIT_BIT] = ind_wdata_in[`NVAC_READ_PERMIT_BIT];
      if (state_q == NVAC_IDLE) begin
        ctrl_d[`NVAC_PROG_START_BIT] = start_ok(ind_wdata_in[`NVAC_PROG_START_BIT],
          ctrl_q[`NVAC_PROG_PERMIT_BIT]);
        ctrl_d[`NVAC_READ_START_BIT] = start_ok(ind_wdata_in[`NVAC_READ_START_BIT],
          ctrl_q[`NVAC_READ_PERMIT_BIT]) && !ctrl_d[`NVAC_PROG_START_BIT];
      end
    end

    // Address is latched for both cycles, data for a program only, so the CPU may reload them mid-cycle
    case (state_q)
      NVAC_IDLE: begin
        if (ctrl_q[`NVAC_PROG_START_BIT]) begin
          lat_addr_d = addr_q;
          lat_data_d = data_q;
          cnt_d = 16'(PROG_CYCLES - 1);
          state_d = NVAC_PROG;
        end else if (ctrl_q[`NVAC_READ_START_BIT]) begin
          lat_addr_d = addr_q;
          cnt_d = 16'(`NVAC_READ_CYCLES - 1);
          state_d = NVAC_READ;
        end
      end
      NVAC_READ: begin
        if (cnt_q == 16'h0000) begin
          data_d = arr.rdata;
          ctrl_d[`NVAC_READ_START_BIT] = 1'b0;
          state_d = NVAC_IDLE;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      NVAC_PROG: begin
        if (cnt_q == 16'h0000) begin
          // One-cycle strobe: the array commits the latched byte here
          arr.wr = 1'b1;
          ctrl_d[`NVAC_PROG_START_BIT] = 1'b0;
          state_d = NVAC_IDLE;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      default: state_d = NVAC_IDLE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= NVAC_IDLE;
      ctrl_q <= `NVAC_CTRL_RST;
      addr_q <= `NVAC_ADDR_RST;
      data_q <= `NVAC_DATA_RST;
      bank_q <= 1'b0;
      lat_addr_q <= `NVAC_ADDR_RST;
      lat_data_q <= `NVAC_DATA_RST;
      cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      data_q <= data_d;
      bank_q <= bank_d;
      lat_addr_q <= lat_addr_d;
      lat_data_q <= lat_data_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************
  // Completion flags and vector
  // ****************************************
  always_comb begin
    done_d = done_q;
    mf_d = mf_q;
    // A completion wins over a clear in the same cycle, so no cycle end is lost
    if (prog_end) begin
      done_d = 1'b1;
      mf_d = 1'b1;
    end else begin
      if (done_flag_clr_in) begin
        done_d = 1'b0;
      end
      if (mf_service_in) begin
        mf_d = 1'b0;
      end
    end
    vec_d = global_irq_enable_in && nv_update_done_irq_enable_in && mf_irq_enable_in &&
      !stack_full_in && mf_q && done_q;
  end

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      done_q <= 1'b0;
      mf_q <= 1'b0;
      vec_q <= 1'b0;
    end else begin
      done_q <= done_d;
      mf_q <= mf_d;
      vec_q <= vec_d;
    end
  end

  // ****************************************
  // Read-back and busy
  // ****************************************
  always_comb begin
    // Read data shows this cycle's update, one cycle after the offset
    case (dir_addr_in)
      `NVAC_ADDR_OFS: dir_rd_d = {2'h0, addr_d};
      `NVAC_DATA_OFS: dir_rd_d = data_d;
      `NVAC_BANK_OFS: dir_rd_d = {7'h00, bank_d};
      default: dir_rd_d = 8'h00;
    endcase
    // Control is invisible unless reached through the bank-one pointer
    ind_rd_d = ctrl_hit(indirect_pointer_one_in, bank_d) ? {4'h0, ctrl_d} : 8'h00;
    // Taken from the next state so busy rises with the first cycle of work
    busy_d = (state_d != NVAC_IDLE);
  end

  always_ff @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dir_rd_q <= 8'h00;
      ind_rd_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      dir_rd_q <= dir_rd_d;
      ind_rd_q <= ind_rd_d;
      busy_q <= busy_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dir_rdata_out = dir_rd_q;
  assign ind_rdata_out = ind_rd_q;
  assign nv_update_done_flag_out = done_q;
  assign mf_irq_flag_out = mf_q;
  assign irq_vector_out = vec_q;
  assign busy_out = busy_q;
endmodule

/* File: verification/nvac_assertions.sv */
/* Port checker of the nonvolatile access controller.
 Assumes binding to nvac_top, one clock domain. */
`timescale 1ns/1ps

module nvac_assertions #(
  parameter int PROG_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Inputs
  input wire logic [7:0] dir_addr_in,
  input wire logic [7:0] indirect_pointer_one_in,
  input wire logic global_irq_enable_in,
  input wire logic nv_update_done_irq_enable_in,
  input wire logic mf_irq_enable_in,
  input wire logic stack_full_in,
  input wire logic done_flag_clr_in,
  input wire logic mf_service_in,
  // Outputs
  input wire logic [7:0] dir_rdata_out,
  input wire logic [7:0] ind_rdata_out,
  input wire logic nv_update_done_flag_out,
  input wire logic mf_irq_flag_out,
  input wire logic irq_vector_out,
  input wire logic busy_out
);
  // Slack covers the latch cycle and the registered busy flag
  localparam int BUSY_MAX = PROG_CYCLES + 4;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_open;
    $rose(busy_out);
  endsequence
  sequence s_done;
    $rose(nv_update_done_flag_out);
  endsequence
  a_cycle_bound: assert property (s_open |-> ##[1:BUSY_MAX] !busy_out)
    else $error("cycle too long");
  a_flag_pair: assert property (s_done |-> mf_irq_flag_out)
    else $error("flags not set together");
  a_flag_cause: assert property (s_done |-> $past(busy_out) || $past(busy_out, 2))
    else $error("done flag without cycle");
  a_vector_gate: assert property (irq_vector_out |-> $past(global_irq_enable_in && nv_update_done_irq_enable_in
    && mf_irq_enable_in && !stack_full_in))
    else $error("vector while disabled");
  a_service_keep: assert property (mf_service_in && nv_update_done_flag_out && !done_flag_clr_in
    |=> nv_update_done_flag_out)
    else $error("service cleared done flag");
  a_service_clear: assert property (mf_service_in && !busy_out |=> !mf_irq_flag_out)
    else $error("service kept flag");
  a_done_clear: assert property (done_flag_clr_in && !busy_out |=> !nv_update_done_flag_out)
    else $error("done flag not cleared");
  a_addr_upper: assert property (dir_addr_in == 8'h00 |=> dir_rdata_out[7:6] == 2'h0)
    else $error("address upper bits set");
  a_ptr_hidden: assert property (indirect_pointer_one_in != 8'h40 |=> ind_rdata_out == 8'h00)
    else $error("control seen off pointer");
endmodule

bind nvac_top nvac_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.clk_in, .rstn_in, .dir_addr_in,
  .indirect_pointer_one_in, .global_irq_enable_in, .nv_update_done_irq_enable_in, .mf_irq_enable_in,
  .stack_full_in, .done_flag_clr_in, .mf_service_in, .dir_rdata_out, .ind_rdata_out,
  .nv_update_done_flag_out, .mf_irq_flag_out, .irq_vector_out, .busy_out);

/* File: verification/testbench.sv */
/* Self-checking bench of the nonvolatile access controller.
 Assumes nvac_pkg and nvac_top compiled first. */
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %h not %h", $time, g, e); end end

module testbench;
  import nvac_pkg::*;
  logic clk_in = 1'h0, rstn_in = 1'h0, dir_wr_in = 1'h0, ind_wr_in = 1'h0;
  logic [7:0] dir_addr_in = 8'h00, dir_wdata_in = 8'h00;
  logic [7:0] indirect_pointer_one_in = 8'h00, ind_wdata_in = 8'h00;
  logic global_irq_enable_in = 1'h0, nv_update_done_irq_enable_in = 1'h0, mf_irq_enable_in = 1'h0;
  logic stack_full_in = 1'h0, done_flag_clr_in = 1'h0, mf_service_in = 1'h0;
  logic [7:0] dir_rdata_out, ind_rdata_out, rd, v;
  logic nv_update_done_flag_out, mf_irq_flag_out, irq_vector_out, busy_out;
  int error_cnt = 0, total_checks = 0;
  nvac_byte_t mem [nvac_addr_t];
  nvac_addr_t a;
  logic [2:0] en;

  // Short program time keeps the run brief
  nvac_top #(.PROG_CYCLES(4)) dut (.clk_in, .rstn_in, .dir_wr_in, .dir_addr_in, .dir_wdata_in, .ind_wr_in,
    .indirect_pointer_one_in, .ind_wdata_in, .global_irq_enable_in, .nv_update_done_irq_enable_in,
    .mf_irq_enable_in, .stack_full_in, .done_flag_clr_in, .mf_service_in, .dir_rdata_out, .ind_rdata_out,
    .nv_update_done_flag_out, .mf_irq_flag_out, .irq_vector_out, .busy_out);
  always #50 clk_in = ~clk_in;

  // ****************************************
  // Bus tasks and expectations
  // ****************************************
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic dwr(logic [7:0] ad, logic [7:0] d);
    dir_addr_in = ad;
    dir_wdata_in = d;
    dir_wr_in = 1'h1;
    tick();
    dir_wr_in = 1'h0;
    tick();
  endtask
  task automatic iwr(logic [7:0] d);
    indirect_pointer_one_in = 8'h40;
    ind_wdata_in = d;
    ind_wr_in = 1'h1;
    tick();
    ind_wr_in = 1'h0;
    tick();
  endtask
  task automatic drd(logic [7:0] ad);
    dir_addr_in = ad;
    tick();
    rd = dir_rdata_out;
  endtask
  task automatic ird(logic [7:0] p);
    indirect_pointer_one_in = p;
    tick();
    rd = ind_rdata_out;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick();
    s = 1'h0;
    tick();
  endtask
  task automatic idle();
    tick(3);
    for (int i = 0; i < 40 && busy_out !== 1'h0; i++) tick();
    `CHK(busy_out, 1'h0)
  endtask
  function automatic logic [7:0] ctrl_after(logic [7:0] c);
    return c & 8'h0A;
  endfunction
  // Enable bits: done enable, multi-function enable, stack full
  function automatic logic vector_exp(logic [2:0] e);
    return e[2] && e[1] && !e[0];
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    void'($urandom(76203));
    tick(5);
    rstn_in = 1'h1;
    tick(3);
    drd(8'h00);
    `CHK(rd, 8'h00)
    drd(8'h01);
    `CHK(rd, 8'h00)
    drd(8'h02);
    `CHK(rd, 8'h00)
    iwr(8'h0A);
    ird(8'h40);
    `CHK(rd, 8'h00)
    dwr(8'h02, 8'($urandom) | 8'h01);
    drd(8'h02);
    `CHK(rd, 8'h01)
    ird(8'h40);
    `CHK(rd, 8'h00)
    iwr(8'h04);
    ird(8'h40);
    `CHK(rd, 8'h00)
    iwr(8'h01);
    ird(8'h40);
    `CHK(rd, 8'h00)
    $display("test reset and guards done");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      en = (i < 2) ? 3'(6 + i) : 3'($urandom);
      a = v[5:0];
      dwr(8'h00, v);
      drd(8'h00);
      `CHK(rd, {2'h0, a})
      mem[a] = 8'($urandom);
      dwr(8'h01, mem[a]);
      {nv_update_done_irq_enable_in, mf_irq_enable_in, stack_full_in} = en;
      global_irq_enable_in = 1'h0;
      iwr(8'h08);
      iwr(8'h0C);
      global_irq_enable_in = 1'h1;
      dwr(8'h00, ~v);
      dwr(8'h01, ~mem[a]);
      idle();
      ird(8'h40);
      `CHK(rd, ctrl_after(8'h0C))
      `CHK(mf_irq_flag_out, 1'h1)
      `CHK(irq_vector_out, vector_exp(en))
      pulse(mf_service_in);
      `CHK({nv_update_done_flag_out, mf_irq_flag_out}, 2'h2)
      pulse(done_flag_clr_in);
      `CHK(nv_update_done_flag_out, 1'h0)
    end
    $display("test program cycles done");
    rstn_in = 1'h0;
    tick(2);
    rstn_in = 1'h1;
    tick(3);
    drd(8'h02);
    `CHK(rd, 8'h00)
    dwr(8'h02, 8'h01);
    ird(8'h40);
    `CHK(rd, 8'h00)
    $display("test mid-run reset done");
    iwr(8'h00);
    dwr(8'h00, {2'h0, a});
    dwr(8'h01, ~mem[a]);
    iwr(8'h04);
    ird(8'h40);
    `CHK(rd, 8'h00)
    foreach (mem[k]) begin
      dwr(8'h00, {2'h0, k});
      iwr(8'h02);
      iwr(8'h03);
      dwr(8'h00, {2'h0, ~k});
      idle();
      ird(8'h40);
      `CHK(rd, ctrl_after(8'h03))
      drd(8'h01);
      `CHK(rd, mem[k])
    end
    $display("test read back done");
    report_and_stop();
  end
endmodule
